/* fsc_consts.svh */
/*
  Constants of the fail-safe clock monitor: register offsets, field
  positions, reset values, mode codes and sample timing.
  Assumes a 50 MHz sample clock and a 4-bit register address.
*/
// Notes on behaviour
// - entering a power-managed mode switches the clock mux to the source in clock_source_select_reg.
// - after that entry the monitor keeps checking the source now in use.
// - on a clock failure the device clock moves to internal_osc_mux and execution goes on there.
// - a failed source is never reselected automatically, only by a software write.
// - with the failure interrupt masked, a later interrupt in Idle resumes execution on internal_osc_mux.
// - in external clock, external RC or internal RC mode monitoring starts right after reset or wake.
// - in crystal modes internal_osc_mux is the device clock until the start-up timer expires, and in the PLL crystal mode the PLL timer too.
// - once the primary clock is stable it becomes the device clock and the RC clock only samples.
// - a primary oscillator that never starts raises no osc_fail_flag; software polls startup_done_status.
// - selecting another power-managed source while the primary still starts disables the primary.
`ifndef FSC_CONSTS_SVH
`define FSC_CONSTS_SVH

`define FSC_ADDR_SEL      4'h0
`define FSC_ADDR_STATUS   4'h4
`define FSC_ADDR_INT_STAT 4'h8
`define FSC_ADDR_INT_MASK 4'hC

`define FSC_SEL_RST       2'h0
`define FSC_MASK_RST      2'h0
`define FSC_INT_FAIL_BIT  0
`define FSC_INT_START_BIT 1

`define FSC_MODE_LP       4'h0
`define FSC_MODE_XT       4'h1
`define FSC_MODE_HS       4'h2
`define FSC_MODE_HIGH_SPEED_CRYSTAL_PLL_MODE    4'h6

`define FSC_CLK_NS        20
`define FSC_SAMPLE_NS     2000
`define FSC_SAMPLE_CYC    ((`FSC_SAMPLE_NS + `FSC_CLK_NS - 1) / `FSC_CLK_NS)

`endif

/* fsc_pkg.sv */
/*
  Types of the fail-safe clock monitor.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package fsc_pkg;
  typedef enum logic [1:0] {
    FSC_SRC_PRI,
    FSC_SRC_SEC,
    FSC_SRC_INT
  } fsc_src_type;

  typedef enum logic [1:0] {
    FSC_ST_BOOT,
    FSC_ST_WAIT,
    FSC_ST_RUN,
    FSC_ST_FAILED
  } fsc_state_type;
endpackage : fsc_pkg
`default_nettype wire

/* fsc_mon_if.sv */
/*
  Link between the controller and the clock activity monitor.
  Assumes both ends run on sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
interface fsc_mon_if;
  import fsc_pkg::*;
  logic        en;
  logic        restart;
  fsc_src_type src;
  logic        fail;
  modport ctl (output en, output restart, output src, input fail);
  modport mon (input en, input restart, input src, output fail);
endinterface : fsc_mon_if
`default_nettype wire

/* fsc_activity_mon.sv */
/*
  Clock activity monitor: looks for edges of the watched clock pin
  within one sample window and pulses fail when none came.
  Assumes watched clocks run below a quarter of sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fsc_consts.svh"
module fsc_activity_mon
  import fsc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic prim_clk_pin,
  input wire logic sec_clk_pin,
  fsc_mon_if.mon   mon
);
  localparam logic [7:0] WIN = 8'(`FSC_SAMPLE_CYC);

  logic [1:0] meta_q;
  logic [1:0] sync_q;
  logic [1:0] last_q;
  logic [7:0] cnt_q;
  logic       fail_q;
  logic       edge_seen;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= 2'h0;
      sync_q <= 2'h0;
      last_q <= 2'h0;
    end
    else
    begin
      meta_q <= {sec_clk_pin, prim_clk_pin};
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  // the second and third flops feed the edge test
  assign edge_seen = (mon.src == FSC_SRC_SEC) ? (sync_q[1] ^ last_q[1])
                                              : (sync_q[0] ^ last_q[0]);

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q  <= 8'h00;
      fail_q <= 1'b0;
    end
    else
    begin
      fail_q <= 1'b0;
      if (!mon.en || mon.restart || edge_seen)
        cnt_q <= 8'h00;
      else if (cnt_q == WIN - 8'h01)
      begin
        cnt_q  <= 8'h00;
        fail_q <= 1'b1;
      end
      else
        cnt_q <= cnt_q + 8'h01;
    end
  end

  assign mon.fail = fail_q;
endmodule : fsc_activity_mon
`default_nettype wire

/* fsc_clock_monitor.sv */
/*
  Fail-safe clock monitor controller: clock source mux select, start-up
  hold on the internal oscillator, failure switch-over, register port
  and interrupt.
  Assumes pm_enter, wake, ext_irq are one-cycle pulses and ost_done,
  pll_done, pm_idle are levels, all from logic on sys_clk.
*/
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "fsc_consts.svh"
module fsc_clock_monitor
  import fsc_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic [3:0] osc_mode,
  input  wire logic       prim_clk_pin,
  input  wire logic       sec_clk_pin,
  input  wire logic       pm_enter,
  input  wire logic       pm_idle,
  input  wire logic       wake,
  input  wire logic       ost_done,
  input  wire logic       pll_done,
  input  wire logic       ext_irq,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  output logic      [1:0] clk_sel,
  output logic            primary_en,
  output logic            cpu_run,
  output logic            irq
);

  //////////////////////////////////////////////////////////////////////
  // decode helpers
  function automatic logic is_crystal(input logic [3:0] m);
    is_crystal = (m == `FSC_MODE_LP) || (m == `FSC_MODE_XT) ||
                 (m == `FSC_MODE_HS) || (m == `FSC_MODE_HIGH_SPEED_CRYSTAL_PLL_MODE);
  endfunction : is_crystal

  // code 3 is not a source; it falls back to the internal oscillator
  function automatic fsc_src_type decode_src(input logic [1:0] f);
    unique case (f)
      2'h0:    decode_src = FSC_SRC_PRI;
      2'h1:    decode_src = FSC_SRC_SEC;
      default: decode_src = FSC_SRC_INT;
    endcase
  endfunction : decode_src

  //////////////////////////////////////////////////////////////////////
  // state
  fsc_mon_if mon_if ();

  fsc_state_type state_q;
  fsc_src_type   clk_sel_q;
  logic    [3:0] mode_q;
  logic    [1:0] sel_q;
  logic    [1:0] int_stat_q;
  logic    [1:0] int_mask_q;
  logic          primary_en_q;
  logic          cpu_run_q;
  logic          irq_q;
  logic          startup_q;
  logic    [7:0] rdata_q;
  logic          sel_wr;
  logic          stat_rd;
  logic          mon_fail;
  logic          timers_done;
  logic    [1:0] int_set;

  assign sel_wr      = reg_wr && (reg_addr == `FSC_ADDR_SEL);
  assign stat_rd     = reg_rd && (reg_addr == `FSC_ADDR_INT_STAT);
  assign mon_fail    = mon_if.fail && (state_q == FSC_ST_RUN);
  // the PLL timer only matters in the PLL crystal mode
  assign timers_done = ost_done &&
                       (pll_done || (mode_q != `FSC_MODE_HIGH_SPEED_CRYSTAL_PLL_MODE));

  //////////////////////////////////////////////////////////////////////
  // activity monitor

  // watch whatever external clock is in use; never during start-up
  assign mon_if.en      = (state_q == FSC_ST_RUN) &&
                          (clk_sel_q != FSC_SRC_INT);
  assign mon_if.restart = pm_enter;
  assign mon_if.src     = clk_sel_q;

  fsc_activity_mon u_mon (
    .sys_clk      (sys_clk),
    .rst          (rst),
    .prim_clk_pin (prim_clk_pin),
    .sec_clk_pin  (sec_clk_pin),
    .mon          (mon_if.mon)
  );

  //////////////////////////////////////////////////////////////////////
  // clock source sequencing

  // the mode straps are caught on the first edge after reset release
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      mode_q <= 4'h0;
    else if (state_q == FSC_ST_BOOT)
      mode_q <= osc_mode;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state_q      <= FSC_ST_BOOT;
      clk_sel_q    <= FSC_SRC_INT;
      primary_en_q <= 1'b1;
    end
    else if (wake)
    begin
      state_q      <= FSC_ST_BOOT;
      clk_sel_q    <= FSC_SRC_INT;
      primary_en_q <= 1'b1;
    end
    else
    begin
      unique case (state_q)
        FSC_ST_BOOT:
        begin
          if (is_crystal(osc_mode))
          begin
            state_q   <= FSC_ST_WAIT;
            clk_sel_q <= FSC_SRC_INT;
          end
          else
          begin
            state_q   <= FSC_ST_RUN;
            clk_sel_q <= FSC_SRC_PRI;
          end
        end
        FSC_ST_WAIT:
        begin
          if (pm_enter && (decode_src(sel_q) != FSC_SRC_PRI))
          begin
            state_q      <= FSC_ST_RUN;
            clk_sel_q    <= decode_src(sel_q);
            primary_en_q <= 1'b0;
          end
          else if (timers_done)
          begin
            state_q   <= FSC_ST_RUN;
            clk_sel_q <= FSC_SRC_PRI;
          end
        end
        FSC_ST_RUN:
        begin
          if (mon_if.fail)
          begin
            state_q   <= FSC_ST_FAILED;
            clk_sel_q <= FSC_SRC_INT;
          end
          else if (pm_enter)
          begin
            clk_sel_q <= decode_src(sel_q);
            if (decode_src(sel_q) == FSC_SRC_PRI)
              primary_en_q <= 1'b1;
          end
        end
        FSC_ST_FAILED:
        begin
          // stay on the internal oscillator until software reselects
          if (sel_wr)
          begin
            state_q   <= FSC_ST_RUN;
            clk_sel_q <= decode_src(reg_wdata[1:0]);
            if (decode_src(reg_wdata[1:0]) == FSC_SRC_PRI)
              primary_en_q <= 1'b1;
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // execution resume
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      cpu_run_q <= 1'b1;
    else if (wake || ext_irq || irq_q)
      cpu_run_q <= 1'b1;
    else if (mon_fail && int_mask_q[`FSC_INT_FAIL_BIT])
      cpu_run_q <= 1'b1;
    else if (pm_enter && pm_idle)
      cpu_run_q <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      sel_q <= `FSC_SEL_RST;
    else if (sel_wr)
      sel_q <= reg_wdata[1:0];
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      int_mask_q <= `FSC_MASK_RST;
    else if (reg_wr && (reg_addr == `FSC_ADDR_INT_MASK))
      int_mask_q <= reg_wdata[1:0];
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      startup_q <= 1'b0;
    else
      startup_q <= ost_done;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      rdata_q <= 8'h00;
    else if (reg_rd)
    begin
      unique case (reg_addr)
        `FSC_ADDR_SEL:      rdata_q <= {6'h00, sel_q};
        `FSC_ADDR_STATUS:   rdata_q <= {3'h0,
                                        state_q == FSC_ST_FAILED,
                                        primary_en_q, startup_q,
                                        clk_sel_q};
        `FSC_ADDR_INT_STAT: rdata_q <= {6'h00, int_stat_q};
        `FSC_ADDR_INT_MASK: rdata_q <= {6'h00, int_mask_q};
        default:            rdata_q <= 8'h00;
      endcase
    end
    else
      rdata_q <= 8'h00;
  end

  //////////////////////////////////////////////////////////////////////
  // interrupt
  always_comb
  begin
    int_set                     = 2'h0;
    int_set[`FSC_INT_FAIL_BIT]  = mon_fail;
    int_set[`FSC_INT_START_BIT] = (state_q == FSC_ST_WAIT) && timers_done;
  end

  // a new event in the clearing read cycle survives the clear
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      int_stat_q <= 2'h0;
    else
      int_stat_q <= (stat_rd ? 2'h0 : int_stat_q) | int_set;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      irq_q <= 1'b0;
    else
      irq_q <= |(int_stat_q & int_mask_q);
  end

  assign reg_rdata  = rdata_q;
  assign clk_sel    = clk_sel_q;
  assign primary_en = primary_en_q;
  assign cpu_run    = cpu_run_q;
  assign irq        = irq_q;

  //////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst || wake);

  sequence s_fail_in_run;
    (state_q == FSC_ST_RUN) && mon_if.fail;
  endsequence

  sequence s_on_internal_failed;
    (clk_sel_q == FSC_SRC_INT) && (state_q == FSC_ST_FAILED);
  endsequence

  property p_fail_switch;
    s_fail_in_run |=> s_on_internal_failed;
  endproperty
  a_fail_switch: assert property (p_fail_switch)
    else $error("failure did not move the clock to internal");

  property p_flag_same_cycle;
    s_fail_in_run |=> int_stat_q[`FSC_INT_FAIL_BIT] and s_on_internal_failed;
  endproperty
  a_flag_same_cycle: assert property (p_flag_same_cycle)
    else $error("fail flag and switch not in the same cycle");

  property p_no_auto_return;
    (state_q == FSC_ST_FAILED) && !sel_wr |=>
      (state_q == FSC_ST_FAILED) && (clk_sel_q == FSC_SRC_INT);
  endproperty
  a_no_auto_return: assert property (p_no_auto_return)
    else $error("left failed source without a reselection");

  property p_pm_select;
    (state_q == FSC_ST_RUN) && pm_enter && !mon_if.fail |=>
      clk_sel_q == decode_src($past(sel_q));
  endproperty
  a_pm_select: assert property (p_pm_select)
    else $error("power-managed entry took the wrong source");

  property p_monitor_on;
    (state_q == FSC_ST_RUN) && pm_enter && !mon_if.fail &&
      (decode_src(sel_q) != FSC_SRC_INT) |=>
      mon_if.en && (mon_if.src == decode_src($past(sel_q)));
  endproperty
  a_monitor_on: assert property (p_monitor_on)
    else $error("source in use is not monitored");

  sequence s_boot_plain;
    (state_q == FSC_ST_BOOT) && !is_crystal(osc_mode);
  endsequence

  property p_plain_start;
    s_boot_plain |=> mon_if.en ##1 (mon_if.en || $past(pm_enter));
  endproperty
  a_plain_start: assert property (p_plain_start)
    else $error("monitoring did not start at once");

  property p_crystal_hold;
    (state_q == FSC_ST_WAIT) |->
      (clk_sel_q == FSC_SRC_INT) && !mon_if.en;
  endproperty
  a_crystal_hold: assert property (p_crystal_hold)
    else $error("device clock left internal during start-up");

  property p_stable_primary;
    (state_q == FSC_ST_WAIT) && timers_done && !pm_enter |=>
      (clk_sel_q == FSC_SRC_PRI) && (state_q == FSC_ST_RUN);
  endproperty
  a_stable_primary: assert property (p_stable_primary)
    else $error("primary not taken once stable");

  property p_no_startup_flag;
    (state_q == FSC_ST_WAIT) && !stat_rd |=>
      int_stat_q[`FSC_INT_FAIL_BIT] ==
        $past(int_stat_q[`FSC_INT_FAIL_BIT]);
  endproperty
  a_no_startup_flag: assert property (p_no_startup_flag)
    else $error("fail flag set during start-up");

  property p_other_mode_stops;
    (state_q == FSC_ST_WAIT) && pm_enter &&
      (decode_src(sel_q) != FSC_SRC_PRI) |=> !primary_en_q;
  endproperty
  a_other_mode_stops: assert property (p_other_mode_stops)
    else $error("primary kept running after another mode");

  property p_idle_resume;
    ext_irq |=> cpu_run_q;
  endproperty
  a_idle_resume: assert property (p_idle_resume)
    else $error("interrupt did not resume execution");
endmodule : fsc_clock_monitor
`default_nettype wire

/* fsc_clock_monitor_tb.sv */
/*
  Self-checking testbench of the fail-safe clock monitor controller.
  Assumes fsc_pkg, fsc_mon_if and the design modules compile first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fsc_consts.svh"
module fsc_clock_monitor_tb;
  import fsc_pkg::*;
  logic       sys_clk, rst, prim_clk_pin, sec_clk_pin;
  logic       pm_enter, pm_idle, wake, ost_done, pll_done, ext_irq;
  logic [3:0] osc_mode, reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic       reg_wr, reg_rd, primary_en, cpu_run, irq;
  logic [1:0] clk_sel;
  logic       prim_on, sec_on;
  logic [2:0] pin_cnt;
  int         num_errors, compares;

  fsc_clock_monitor uut (.sys_clk(sys_clk), .rst(rst), .osc_mode(osc_mode),
    .prim_clk_pin(prim_clk_pin), .sec_clk_pin(sec_clk_pin),
    .pm_enter(pm_enter), .pm_idle(pm_idle), .wake(wake),
    .ost_done(ost_done), .pll_done(pll_done), .ext_irq(ext_irq),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .clk_sel(clk_sel),
    .primary_en(primary_en), .cpu_run(cpu_run), .irq(irq));

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // clock pins toggle every 4 cycles, well below the sync limit
  always @(posedge sys_clk)
  begin
    pin_cnt      <= pin_cnt + 3'h1;
    prim_clk_pin <= prim_on & pin_cnt[2];
    sec_clk_pin  <= sec_on & pin_cnt[2];
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("TB: errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [7:0] seen,
                     input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] exp,
                    input string what);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(what, reg_rdata, exp);
  endtask : rd

  task automatic enter_pm(input logic idle);
    @(posedge sys_clk);
    pm_idle  <= idle;
    pm_enter <= 1'b1;
    @(posedge sys_clk);
    pm_enter <= 1'b0;
    #1;
  endtask : enter_pm

  // a failure must switch the mux within a few sample windows
  task automatic wait_sel(input logic [1:0] want);
    int n;
    n = 0;
    while (clk_sel !== want && n < 400)
    begin
      cyc(1);
      n++;
    end
    chk("clk_sel wait", 8'(clk_sel), 8'(want));
    if (clk_sel !== want)
      test_done();
  endtask : wait_sel

  task automatic reset_dut(input logic [3:0] mode);
    @(posedge sys_clk);
    rst      <= 1'b1;
    osc_mode <= mode;
    ost_done <= 1'b0;
    pll_done <= 1'b0;
    pm_idle  <= 1'b0;
    repeat (20) @(posedge sys_clk);
    chk("clk_sel in reset", 8'(clk_sel), 8'h02);
    chk("flags in reset", {5'h00, primary_en, cpu_run, irq}, 8'h06);
    rst <= 1'b0;
    cyc(1);
  endtask : reset_dut

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (100000) @(posedge sys_clk);
    num_errors++;
    $display("CHECK FAILED watchdog expected finish seen hang");
    test_done();
  end

  initial
  begin
    rst          = 1'b1;
    osc_mode     = `FSC_MODE_HS;
    pm_enter     = 1'b0;
    pm_idle      = 1'b0;
    wake         = 1'b0;
    ost_done     = 1'b0;
    pll_done     = 1'b0;
    ext_irq      = 1'b0;
    reg_addr     = 4'h0;
    reg_wdata    = 8'h00;
    reg_wr       = 1'b0;
    reg_rd       = 1'b0;
    prim_on      = 1'b0;
    sec_on       = 1'b0;
    pin_cnt      = 3'h0;
    prim_clk_pin = 1'b0;
    sec_clk_pin  = 1'b0;
    num_errors   = 0;
    compares     = 0;
    // crystal that never starts: held on internal, no failure flagged
    reset_dut(`FSC_MODE_HS);
    rd(`FSC_ADDR_INT_MASK, 8'h00, "mask reset");
    rd(`FSC_ADDR_SEL, 8'h00, "sel reset");
    cyc(150);
    chk("clk_sel start-up", 8'(clk_sel), 8'h02);
    rd(`FSC_ADDR_INT_STAT, 8'h00, "no fail flag");
    wr(`FSC_ADDR_STATUS, 8'hFF);
    // primary enabled, start-up not done, on internal
    rd(`FSC_ADDR_STATUS, 8'h0A, "status read-only");
    rd(4'h2, 8'h00, "unmapped read");
    wr(`FSC_ADDR_SEL, 8'h01);
    enter_pm(1'b0);
    chk("sel during start-up", 8'(clk_sel), 8'h01);
    chk("primary off", 8'(primary_en), 8'h00);
    // entry onto primary turns the oscillator back on
    wr(`FSC_ADDR_SEL, 8'h00);
    enter_pm(1'b0);
    chk("pm entry primary", {5'h00, primary_en, clk_sel}, 8'h04);
    // pll crystal: both timers needed, then primary takes over
    prim_on <= 1'b1;
    reset_dut(`FSC_MODE_HIGH_SPEED_CRYSTAL_PLL_MODE);
    wr(`FSC_ADDR_INT_MASK, 8'h02);
    ost_done <= 1'b1;
    cyc(5);
    chk("clk_sel pll wait", 8'(clk_sel), 8'h02);
    @(posedge sys_clk);
    pll_done <= 1'b1;
    wait_sel(2'h0);
    cyc(2);
    chk("irq start-up", 8'(irq), 8'h01);
    rd(`FSC_ADDR_INT_STAT, 8'h02, "start-up flag");
    cyc(2);
    chk("irq cleared", 8'(irq), 8'h00);
    // power-managed entry onto secondary, then its failure
    sec_on <= 1'b1;
    wr(`FSC_ADDR_SEL, 8'h01);
    enter_pm(1'b0);
    chk("clk_sel pm entry", 8'(clk_sel), 8'h01);
    cyc(150);
    chk("no false fail", 8'(clk_sel), 8'h01);
    sec_on <= 1'b0;
    wait_sel(2'h2);
    rd(`FSC_ADDR_INT_STAT, 8'h01, "fail flag with switch");
    chk("irq masked out", 8'(irq), 8'h00);
    sec_on <= 1'b1;
    cyc(200);
    chk("no auto return", 8'(clk_sel), 8'h02);
    wr(`FSC_ADDR_SEL, 8'h00);
    cyc(2);
    chk("reselect primary", 8'(clk_sel), 8'h00);
    // wake restarts the crystal hold; both timers are already done
    @(posedge sys_clk);
    wake <= 1'b1;
    @(posedge sys_clk);
    wake <= 1'b0;
    #1;
    chk("wake on internal", 8'(clk_sel), 8'h02);
    cyc(2);
    chk("wake to primary", 8'(clk_sel), 8'h00);
    rd(`FSC_ADDR_INT_STAT, 8'h02, "wake start-up flag");
    // entry onto the internal oscillator code
    wr(`FSC_ADDR_SEL, 8'h02);
    enter_pm(1'b0);
    chk("pm entry internal", 8'(clk_sel), 8'h02);
    // non-crystal, enabled failure in idle
    reset_dut(4'h4);
    chk("immediate monitor", 8'(clk_sel), 8'h00);
    wr(`FSC_ADDR_INT_MASK, 8'h01);
    enter_pm(1'b1);
    cyc(1);
    chk("idle stops cpu", 8'(cpu_run), 8'h00);
    prim_on <= 1'b0;
    wait_sel(2'h2);
    cyc(2);
    chk("run on internal", 8'(cpu_run), 8'h01);
    chk("irq fail", 8'(irq), 8'h01);
    rd(`FSC_ADDR_INT_STAT, 8'h01, "fail flag");
    cyc(2);
    chk("irq after clear", 8'(irq), 8'h00);
    // disabled failure in idle: a later interrupt resumes
    prim_on <= 1'b1;
    reset_dut(4'h4);
    enter_pm(1'b1);
    prim_on <= 1'b0;
    wait_sel(2'h2);
    cyc(2);
    chk("stay idle", {6'h00, cpu_run, irq}, 8'h00);
    @(posedge sys_clk);
    ext_irq <= 1'b1;
    @(posedge sys_clk);
    ext_irq <= 1'b0;
    cyc(2);
    chk("resume on irq", 8'(cpu_run), 8'h01);
    chk("still internal", 8'(clk_sel), 8'h02);
    test_done();
  end
endmodule : fsc_clock_monitor_tb
`default_nettype wire
